// [rtl/ictl_top.sv]
`timescale 1ns/1ps
module ictl_top
    import ictl_pkg::*;
#(
    parameter int DOM_TICKS  = DOM_TICKS_DEF,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    input  wire logic i_clk,
    input  wire logic i_nrst,
    input  wire logic i_txd,
    input  wire logic i_low_power_request,
    input  wire logic i_line_fault,
    input  wire logic i_temp_over,
    input  wire logic i_temp_below_hyst,
    input  wire logic i_diff_above_hi,
    input  wire logic i_diff_below_lo,
    output logic      o_rxd,
    output logic      o_txd_ready,
    output logic      o_drive_dominant,
    output logic      o_bus_hiz,
    output logic      o_standby,
    output logic      o_timeout
);

    // ****************************************************
    // state
    // ****************************************************
    typedef struct packed {
        logic             last_push;
        logic             tx_lvl;
        logic [CNT_W-1:0] tick_cnt;
        logic [CNT_W-1:0] dom_cnt;
        logic             timeout;
        logic             thermal;
        logic             dominant;
        logic             hiz;
        logic             standby;
        logic             txd_ready;
    } ictl_st_t;

    ictl_st_t   s_q;
    ictl_st_t   s_d;
    ictl_mode_t mode;
    logic       rxd_raw;
    logic       tick;
    logic       fall;
    logic       rise;
    logic       new_lvl;

    ictl_fifo_if #(.WIDTH(1)) txq ();

    // ****************************************************
    // transmit level crossing toward the bus side
    // ****************************************************
    // only level changes are queued; a refused push retries while
    // the input still differs from the last level accepted
    assign txq.wr_valid = (i_txd != s_q.last_push);
    assign txq.wr_data  = i_txd;
    // queue read side stalls during thermal shutdown; writes are still accepted until the queue is full
    assign txq.rd_ready = ~s_q.thermal;

    ictl_fifo #(
        .WIDTH (1),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .bus    (txq)
    );

    assign new_lvl = (txq.rd_valid & txq.rd_ready) ? txq.rd_data
                                                    : s_q.tx_lvl;
    assign fall    = s_q.tx_lvl & ~new_lvl;
    assign rise    = ~s_q.tx_lvl & new_lvl;
    assign tick    = (s_q.tick_cnt == CNT_W'(TICK_CYC - 1));

    // ****************************************************
    // mode decode
    // ****************************************************
    always_comb begin
        if (s_q.thermal) begin
            mode = ICTL_THERMAL;
        end else if (i_low_power_request) begin
            mode = ICTL_STANDBY;
        end else if (s_q.timeout) begin
            mode = ICTL_TIMEOUT;
        end else begin
            mode = ICTL_NORMAL;
        end
    end

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        s_d = s_q;
        if (txq.wr_valid & txq.wr_ready) begin
            s_d.last_push = i_txd;
        end
        s_d.tx_lvl = new_lvl;

        s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + 1'b1;

        // dominant time counted in ticks from each falling edge
        if (fall || new_lvl) begin
            s_d.dom_cnt = '0;
        end else if (tick && !s_q.timeout) begin
            s_d.dom_cnt = s_q.dom_cnt + 1'b1;
        end

        if (rise) begin
            s_d.timeout = 1'b0;
        end else if (!new_lvl && s_q.dom_cnt > CNT_W'(DOM_TICKS)) begin
            s_d.timeout = 1'b1;
        end

        // set wins over the clear
        if (i_temp_over) begin
            s_d.thermal = 1'b1;
        end else if (i_temp_below_hyst) begin
            s_d.thermal = 1'b0;
        end

        s_d.dominant = (mode == ICTL_NORMAL) && !new_lvl
                       && !i_line_fault;
        s_d.hiz      = s_q.thermal || i_line_fault;
        s_d.standby  = (mode == ICTL_STANDBY);
        s_d.txd_ready = txq.wr_ready;
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            s_q           <= '0;
            s_q.last_push <= TXD_RST;
            s_q.tx_lvl    <= TXD_RST;
            s_q.txd_ready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************
    // receiver
    // ****************************************************
    ictl_rx_cmp u_rx (
        .i_clk           (i_clk),
        .i_nrst          (i_nrst),
        .i_enable        (~s_q.thermal),
        .i_diff_above_hi (i_diff_above_hi),
        .i_diff_below_lo (i_diff_below_lo),
        .o_rxd           (rxd_raw)
    );

    assign o_rxd            = rxd_raw;
    assign o_txd_ready      = s_q.txd_ready;
    assign o_drive_dominant = s_q.dominant;
    assign o_bus_hiz        = s_q.hiz;
    assign o_standby        = s_q.standby;
    assign o_timeout        = s_q.timeout;
endmodule

// [rtl/ictl_pkg.sv]
// Behaviour
// - transmit input low drives the bus dominant, high leaves it recessive.
// - receive output high while bus recessive, low while bus dominant.
// - low power request high disables driver and enters standby, except during thermal shutdown.
// - transmit low longer than the timeout disables transmitter, bus goes recessive.
// - after a timeout, transmission returns only on a later transmit rising edge.
// - bus pins go high impedance while a line is beyond the fault limits.
// - over-temperature switches the device off, bus high impedance, all disabled; the transmit queue accepts level changes until full and replays them later.
// - thermal shutdown ends only once temperature falls below the lower limit.
// - receive low above upper diff threshold, high below lower threshold.
// - receive reads high when lines are shorted or undriven.
package ictl_pkg;

    // ****************************************************
    // timing
    // ****************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_NS       = 1000;
    localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int DOM_TICKS_DEF = 1000;
    localparam int CNT_W         = 16;

    // ****************************************************
    // reset values
    // ****************************************************
    localparam logic RXD_RST = 1'b1;
    localparam logic TXD_RST = 1'b1;

    // ****************************************************
    // transmit path buffering
    // ****************************************************
    localparam int FIFO_DEPTH_DEF = 32;
    localparam int FIFO_WIDTH_DEF = 1;

    typedef enum logic [1:0] {
        ICTL_NORMAL  = 2'b00,
        ICTL_STANDBY = 2'b01,
        ICTL_TIMEOUT = 2'b10,
        ICTL_THERMAL = 2'b11
    } ictl_mode_t;

endpackage

// [rtl/ictl_fifo_if.sv]
`timescale 1ns/1ps
interface ictl_fifo_if #(
    parameter int WIDTH = 1
);
    logic             wr_valid;
    logic             wr_ready;
    logic [WIDTH-1:0] wr_data;
    logic             rd_valid;
    logic             rd_ready;
    logic [WIDTH-1:0] rd_data;

    modport fill  (output wr_valid, output wr_data, input wr_ready,
                   input rd_valid, input rd_data, output rd_ready);
    modport fifo  (input wr_valid, input wr_data, output wr_ready,
                   output rd_valid, output rd_data, input rd_ready);
endinterface

// [rtl/ictl_fifo.sv]
`timescale 1ns/1ps
module ictl_fifo
    import ictl_pkg::*;
#(
    parameter int WIDTH = FIFO_WIDTH_DEF,
    parameter int DEPTH = FIFO_DEPTH_DEF
) (
    input  wire logic i_clk,
    input  wire logic i_nrst,
    ictl_fifo_if.fifo bus
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } ictl_fst_t;

    ictl_fst_t        s_q;
    ictl_fst_t        s_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign bus.wr_ready = (s_q.cnt != (AW+1)'(DEPTH));
    assign bus.rd_valid = (s_q.cnt != '0);
    assign bus.rd_data  = mem[s_q.rp];
    assign push         = bus.wr_valid & bus.wr_ready;
    assign pop          = bus.rd_valid & bus.rd_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.wp = (s_q.wp == AW'(DEPTH-1)) ? '0 : s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = (s_q.rp == AW'(DEPTH-1)) ? '0 : s_q.rp + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[s_q.wp] <= bus.wr_data;
        end
    end
endmodule

// [rtl/ictl_rx_cmp.sv]
`timescale 1ns/1ps
module ictl_rx_cmp
    import ictl_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_nrst,
    input  wire logic i_enable,
    input  wire logic i_diff_above_hi,
    input  wire logic i_diff_below_lo,
    output logic      o_rxd
);
    typedef struct packed {
        logic rxd;
    } ictl_rst_t;

    ictl_rst_t s_q;
    ictl_rst_t s_d;

    always_comb begin
        s_d = s_q;
        if (!i_enable) begin
            s_d.rxd = 1'b1;
        end else if (i_diff_above_hi) begin
            s_d.rxd = 1'b0;
        end else if (i_diff_below_lo) begin
            s_d.rxd = 1'b1;
        end
        // otherwise hold: inside the hysteresis band
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            s_q.rxd <= RXD_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rxd = s_q.rxd;
endmodule

// [dv/ictl_top_assertions.sv]
`timescale 1ns/1ps
module ictl_top_assertions
    import ictl_pkg::*;
#(
    parameter int DOM_TICKS  = DOM_TICKS_DEF,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_txd,
    input wire logic i_low_power_request,
    input wire logic i_line_fault,
    input wire logic i_temp_over,
    input wire logic i_temp_below_hyst,
    input wire logic i_diff_above_hi,
    input wire logic i_diff_below_lo,
    input wire logic o_rxd,
    input wire logic o_txd_ready,
    input wire logic o_drive_dominant,
    input wire logic o_bus_hiz,
    input wire logic o_standby,
    input wire logic o_timeout
);
    // ********
    // port checks
    // ********
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    sequence s_hot;
        i_temp_over ##1 1'b1;
    endsequence
    sequence s_rel;
        o_timeout && !o_bus_hiz && $rose(i_txd);
    endsequence
    AST_RX_DOM: assert property (
        i_diff_above_hi && !i_temp_over && !$past(i_temp_over)
        && !o_bus_hiz |=> !o_rxd) else $error("rxd not low");
    AST_RX_REC: assert property (
        i_diff_below_lo && !i_diff_above_hi |=> o_rxd)
        else $error("rxd not high");
    AST_RX_HOLD: assert property (
        !i_diff_above_hi && !i_diff_below_lo && !i_temp_over
        && !$past(i_temp_over) && !o_bus_hiz |=> $stable(o_rxd))
        else $error("rxd moved");
    AST_NO_DRV: assert property (
        o_drive_dominant |-> !o_standby && !o_bus_hiz)
        else $error("drive while off");
    AST_TO_DROP: assert property (
        $rose(o_timeout) |=> !o_drive_dominant)
        else $error("drive after timeout");
    AST_TO_CLR: assert property (
        s_rel |-> ##[1:40] !o_timeout) else $error("timeout stuck");
    AST_STBY: assert property (
        i_low_power_request && !i_temp_over && !$past(i_temp_over)
        && !o_bus_hiz |=> o_standby)
        else $error("no standby");
    AST_FAULT: assert property (
        i_line_fault |=> o_bus_hiz && !o_drive_dominant)
        else $error("fault not hiz");
    AST_THERM: assert property (
        s_hot |=> o_bus_hiz && o_rxd && !o_drive_dominant)
        else $error("thermal not off");
    AST_THERM_KEEP: assert property (
        o_bus_hiz && !$past(i_line_fault) && !$past(i_temp_below_hyst)
        |=> o_bus_hiz) else $error("thermal left early");
endmodule

bind ictl_top ictl_top_assertions #(.DOM_TICKS(DOM_TICKS),
    .FIFO_DEPTH(FIFO_DEPTH)) u_chk (.*);

// [dv/ictl_ctrl_model.sv]
`timescale 1ns/1ps
module ictl_ctrl_model #(
    parameter int BIT_CYC = 3
) (
    input  wire logic        i_clk,
    input  wire logic        i_send,
    input  wire logic [10:0] i_bits,
    input  wire logic        i_stuck,
    output logic             o_txd,
    output logic             o_busy
);
    // ********
    // frame sender, lsb first, then idle recessive
    // ********
    logic [10:0] sh = 11'h7ff;
    int          n  = 0;
    int          c  = 0;
    initial o_txd = 1'b1;
    assign o_busy = (n != 0) || (c != 0);
    // at most 11 bits a frame, fast bit time
    always @(negedge i_clk) begin
        if (i_stuck) begin
            o_txd <= 1'b0;
        end else if (o_busy) begin
            if (c == 0) begin
                o_txd <= sh[0];
                sh    <= sh >> 1;
                n     <= n - 1;
                c     <= BIT_CYC - 1;
            end else begin
                c <= c - 1;
            end
        end else begin
            o_txd <= 1'b1;
            if (i_send) begin
                sh <= i_bits;
                n  <= 11;
            end
        end
    end
endmodule

// [dv/ictl_top_tb_top.sv]
`timescale 1ns/1ps
module ictl_top_tb_top;
    import ictl_pkg::*;
    localparam int DT = 5;
    logic        clk   = 1'b0;
    logic        nrst  = 1'b0;
    logic        lpr   = 1'b0;
    logic        flt   = 1'b0;
    logic        hot   = 1'b0;
    logic        cool  = 1'b0;
    logic        ahi   = 1'b0;
    logic        blo   = 1'b1;
    logic        stuck = 1'b0;
    logic        send  = 1'b0;
    logic        lp    = 1'b0;
    logic [10:0] bits  = 11'h000;
    logic        txd, rxd, rdy, drv, hiz, stb, tmo, busy;
    logic [8:0]  rows [6] = '{9'h018, 9'h124, 9'h000, 9'h199, 9'h15a,
                              9'h018};
    int          num_errors  = 0;
    int          comparisons = 0;
    int          k;
    // ********
    // harness
    // ********
    ictl_ctrl_model u_ctrl (.i_clk(clk), .i_send(send), .i_bits(bits),
        .i_stuck(stuck), .o_txd(txd), .o_busy(busy));
    ictl_top #(.DOM_TICKS(DT)) DUT (.i_clk(clk), .i_nrst(nrst),
        .i_txd(txd), .i_low_power_request(lpr), .i_line_fault(flt),
        .i_temp_over(hot), .i_temp_below_hyst(cool),
        .i_diff_above_hi(ahi), .i_diff_below_lo(blo), .o_rxd(rxd),
        .o_txd_ready(rdy), .o_drive_dominant(drv), .o_bus_hiz(hiz),
        .o_standby(stb), .o_timeout(tmo));
    initial forever #(CLK_PERIOD_NS / 2) clk = ~clk;
    // bus loopback: comparators follow our own driver
    always @(negedge clk) if (lp) begin
        ahi <= drv & ~hiz;
        blo <= ~(drv & ~hiz);
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string s, input logic [7:0] g,
                       input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic frame(input logic [10:0] b);
        bits <= b;
        send <= 1'b1;
        cyc(1);
        send <= 1'b0;
        cyc(1);
        for (k = 0; busy === 1'b1 && k < 100; k++) cyc(1);
        if (k >= 100) num_errors++;
    endtask
    task automatic test_done;
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #(CLK_PERIOD_NS * 3000);
        num_errors++;
        test_done();
    end
    initial begin
        logic [8:0] r;
        cyc(10);
        chk("reset", {rxd, rdy, drv, hiz, stb, tmo}, 8'h30);
        nrst = 1'b1;
        foreach (rows[i]) begin
            r = rows[i];
            {stuck, lpr, flt, ahi, blo} <= r[8:4];
            cyc(6);
            chk("row", {rxd, drv}, r[3:2]);
            chk("row", {hiz, stb}, r[1:0]);
        end
        $display("test rows done");
        stuck <= 1'b1;
        for (k = 0; tmo !== 1'b1 && k < 200; k++) cyc(1);
        r = 9'((k >= (DT - 1) * TICK_CYC) && (k <= (DT + 3) * TICK_CYC));
        chk("trip", r[7:0], 8'h01);
        cyc(1);
        chk("drop", drv, 8'h00);
        cyc(30);
        chk("held", {tmo, drv}, 8'h02);
        stuck <= 1'b0;
        cyc(6);
        chk("clear", tmo, 8'h00);
        stuck <= 1'b1;
        cyc(6);
        chk("again", drv, 8'h01);
        stuck <= 1'b0;
        cyc(6);
        $display("test timeout done");
        lp = 1'b1;
        frame(11'h000);
        chk("frame", {tmo, drv}, 8'h01);
        cyc(6);
        chk("frame_rx", rxd, 8'h01);
        $display("test frame done");
        lp = 1'b0;
        {hot, ahi, blo} <= 3'h6;
        cyc(3);
        chk("hot", {hiz, rxd, drv}, 8'h06);
        repeat (3) frame(11'h2aa);
        chk("full", rdy, 8'h00);
        {hot, ahi, blo} <= 3'h1;
        cyc(5);
        chk("keep", hiz, 8'h01);
        cool <= 1'b1;
        cyc(3);
        chk("cool", hiz, 8'h00);
        cool <= 1'b0;
        for (k = 0; rdy !== 1'b1 && k < 100; k++) cyc(1);
        // all 32 queued changes must have replayed before the look
        cyc(40);
        chk("drain", {rdy, drv, tmo}, 8'h04);
        $display("test thermal done");
        stuck <= 1'b1;
        cyc(4);
        nrst = 1'b0;
        cyc(2);
        chk("rst_mid", {rxd, rdy, drv, hiz, stb, tmo}, 8'h30);
        nrst = 1'b1;
        cyc(6);
        chk("rst_drv", {tmo, drv}, 8'h01);
        stuck <= 1'b0;
        cyc(6);
        $display("test reset done");
        test_done();
    end
endmodule
